// >>> src/scr_config_regs.sv
// Serial configuration registers: revision, line rate and async output type
//
// How it works
// - Read-only revision word: major, minor, feature, patch bytes at positions 0 to 3.
// - Patch numbers above 100 flag a custom build.
// - Line rate accepts only the nine listed rates.
// - Optional port selector 1 or 2; otherwise rate goes to the arrival port.
// - Reply echoes the port selector only when the host gave one.
// - Reply leaves at the old rate before the port switches rate.
// - Output type zero stops all automatic output on that port.
// - Output type accepts only the listed data set codes.
// - Nonzero type emits packets paced by the output rate setting.
// - Optional port selector for output type; otherwise the arrival port.
// - Output rate limited to 1 to 200 Hz listed values.
// - Pause halts automatic output on the arrival port; resume restarts it.
`timescale 1ns/1ps
`default_nettype none
`include "scr_params.svh"
module scr_config_regs #(
  parameter int CLK_HZ = 50000000,
  parameter logic [7:0] REV_MAJOR = 8'h01,   // Arbitrary value
  parameter logic [7:0] REV_MINOR = 8'h00,   // Arbitrary value
  parameter logic [7:0] REV_FEATURE = 8'h00, // Arbitrary value
  parameter logic [7:0] REV_PATCH = 8'h00    // Arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire scr_pkg::scr_cmd_t cmd,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output scr_pkg::scr_rsp_t rsp,
  input wire logic [1:0] tx_idle,
  input wire logic [1:0][31:0] async_output_rate,
  output logic [1:0][31:0] line_rate,
  output logic [1:0] rate_switch,
  output logic [1:0][7:0] async_output_type_select,
  output logic [1:0] async_paused,
  output logic [1:0] async_emit,
  output logic custom_build
);
  localparam int CMD_W = $bits(scr_pkg::scr_cmd_t);

  function automatic logic rate_ok(input logic [31:0] r);
    case (r)
      `SCR_RATE_9600, `SCR_RATE_19200, `SCR_RATE_38400, `SCR_RATE_57600,
      `SCR_RATE_115200, `SCR_RATE_128000, `SCR_RATE_230400, `SCR_RATE_460800,
      `SCR_RATE_921600: rate_ok = 1'b1;
      default: rate_ok = 1'b0;
    endcase
  endfunction

  function automatic logic type_ok(input logic [31:0] t);
    case (t)
      32'h00, 32'h01, 32'h02, 32'h08, 32'h0A, 32'h0B, 32'h0C, 32'h0D, 32'h0E,
      32'h10, 32'h11, 32'h13, 32'h14, 32'h15, 32'h16, 32'h17,
      32'h1C, 32'h1D, 32'h1E: type_ok = 1'b1;
      default: type_ok = 1'b0;
    endcase
  endfunction

  // Cycles between emits; unlisted rates leave output idle
  function automatic logic [31:0] period_of(input logic [31:0] hz);
    case (hz)
      32'd1, 32'd2, 32'd4, 32'd5, 32'd10, 32'd20, 32'd25, 32'd40, 32'd50,
      32'd100, 32'd200: period_of = 32'(CLK_HZ) / hz;
      default: period_of = 32'h0;
    endcase
  endfunction

  logic f_valid;
  scr_pkg::scr_cmd_t f_cmd;
  scr_pkg::scr_state_t state_reg;
  scr_pkg::scr_rsp_t rsp_next;
  logic [31:0] pend_rate_reg;
  logic pend_port_reg;
  logic pend_reg, pend_next;
  logic [1:0][31:0] line_rate_next;
  logic [1:0][7:0] type_next;
  logic [1:0] paused_next;

  wire take = f_valid && state_reg == scr_pkg::SCR_IDLE;
  wire pop = take;

  // Commands wait here while a reply or a rate switch is in progress
  scr_fifo #(.WIDTH(CMD_W), .DEPTH(`SCR_FIFO_DEPTH)) u_cmd_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_cmd)
  );

  wire sel_first = f_cmd.port_sel == `SCR_PORT_FIRST;
  wire sel_second = f_cmd.port_sel == `SCR_PORT_SECOND;
  wire port_bad = f_cmd.port_given && !sel_first && !sel_second;
  wire tgt = f_cmd.port_given ? sel_second : f_cmd.src_port;
  wire is_wr = f_cmd.kind == scr_pkg::SCR_CMD_WRITE;
  wire is_async = f_cmd.kind == scr_pkg::SCR_CMD_ASYNC;
  wire id_fw = f_cmd.reg_id == `SCR_REG_FW_REV;
  wire id_rate = f_cmd.reg_id == `SCR_REG_LINE_RATE;
  wire id_type = f_cmd.reg_id == `SCR_REG_ASYNC_TYPE;
  wire rate_bad = is_wr && id_rate && !rate_ok(f_cmd.value);
  wire type_bad = is_wr && id_type && !type_ok(f_cmd.value);
  wire [31:0] fw_word = {REV_PATCH, REV_FEATURE, REV_MINOR, REV_MAJOR};
  wire rate_wr_ok = take && is_wr && id_rate && !rate_bad && !port_bad;
  wire type_wr_ok = take && is_wr && id_type && !type_bad && !port_bad;
  wire pause_hit = take && is_async;
  wire rsp_done = rsp_valid && rsp_ready;

  always_comb begin
    rsp_next = rsp;
    rsp_next.kind = f_cmd.kind;
    rsp_next.reg_id = f_cmd.reg_id;
    rsp_next.src_port = f_cmd.src_port;
    rsp_next.port_given = f_cmd.port_given;
    rsp_next.port_sel = f_cmd.port_given ? f_cmd.port_sel : 8'h00;
    rsp_next.value = f_cmd.value;
    rsp_next.err = `SCR_ERR_NONE;
    if (is_async) begin
      rsp_next.value = f_cmd.value;
    end else if (id_fw) begin
      rsp_next.value = fw_word;
      rsp_next.port_given = 1'b0;
      rsp_next.port_sel = 8'h00;
      rsp_next.err = is_wr ? `SCR_ERR_READ_ONLY : `SCR_ERR_NONE;
    end else if (id_rate || id_type) begin
      if (port_bad || rate_bad || type_bad) begin
        rsp_next.err = `SCR_ERR_INVALID_PARAM;
      end else if (!is_wr) begin
        rsp_next.value = id_rate ? line_rate[tgt] : {24'h0, async_output_type_select[tgt]};
      end
    end else begin
      rsp_next.err = `SCR_ERR_INVALID_REG;
    end
  end

  always_comb begin
    pend_next = pend_reg;
    line_rate_next = line_rate;
    type_next = async_output_type_select;
    paused_next = async_paused;
    if (rate_wr_ok) begin
      pend_next = 1'b1;
    end
    // New rate lands only once the reply has fully left the port
    if (state_reg == scr_pkg::SCR_WAIT_TX && tx_idle[pend_port_reg]) begin
      line_rate_next[pend_port_reg] = pend_rate_reg;
      pend_next = 1'b0;
    end
    if (type_wr_ok) begin
      type_next[tgt] = f_cmd.value[7:0];
    end
    if (pause_hit) begin
      paused_next[f_cmd.src_port] = !f_cmd.value[0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= scr_pkg::SCR_IDLE;
    end else begin
      case (state_reg)
        scr_pkg::SCR_IDLE: begin
          if (take) begin
            state_reg <= scr_pkg::SCR_REPLY;
          end
        end
        scr_pkg::SCR_REPLY: begin
          if (rsp_done) begin
            state_reg <= pend_reg ? scr_pkg::SCR_WAIT_TX : scr_pkg::SCR_IDLE;
          end
        end
        scr_pkg::SCR_WAIT_TX: begin
          // Tx idle sampled a cycle after handoff so the reply has started
          if (tx_idle[pend_port_reg]) begin
            state_reg <= scr_pkg::SCR_IDLE;
          end
        end
        default: state_reg <= scr_pkg::SCR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= take || (rsp_valid && !rsp_ready);
      if (take) begin
        rsp <= rsp_next;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_reg <= 1'b0;
      pend_rate_reg <= `SCR_LINE_RATE_RESET;
      pend_port_reg <= 1'b0;
      line_rate <= {2{`SCR_LINE_RATE_RESET}};
      rate_switch <= 2'b00;
      async_output_type_select <= {2{`SCR_ASYNC_TYPE_RESET}};
      async_paused <= 2'b00;
      custom_build <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      if (rate_wr_ok) begin
        pend_rate_reg <= f_cmd.value;
        pend_port_reg <= tgt;
      end
      line_rate <= line_rate_next;
      rate_switch <= {line_rate_next[1] != line_rate[1], line_rate_next[0] != line_rate[0]};
      async_output_type_select <= type_next;
      async_paused <= paused_next;
      custom_build <= REV_PATCH > `SCR_PATCH_CUSTOM_MIN;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pace
      logic [31:0] cnt_reg;
      wire [31:0] period = period_of(async_output_rate[p]);
      wire tick = period != 32'h0 && cnt_reg >= period - 32'h1;
      wire live = async_output_type_select[p] != `SCR_ASYNC_TYPE_OFF && !async_paused[p];
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cnt_reg <= 32'h0;
          async_emit[p] <= 1'b0;
        end else begin
          cnt_reg <= tick ? 32'h0 : cnt_reg + 32'h1;
          async_emit[p] <= tick && live;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> src/scr_params.svh
// Constants for the serial configuration register block
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH
`define SCR_REG_FW_REV 8'h04
`define SCR_REG_LINE_RATE 8'h05
`define SCR_REG_ASYNC_TYPE 8'h06
`define SCR_PORT_FIRST 8'h01
`define SCR_PORT_SECOND 8'h02
`define SCR_PATCH_CUSTOM_MIN 8'h64
`define SCR_LINE_RATE_RESET 32'h0001_C200
`define SCR_ASYNC_TYPE_OFF 8'h00
`define SCR_ASYNC_TYPE_RESET 8'h00
`define SCR_ERR_NONE 8'h00
`define SCR_ERR_INVALID_PARAM 8'h04
`define SCR_ERR_INVALID_REG 8'h05
`define SCR_ERR_READ_ONLY 8'h06
`define SCR_RATE_9600 32'h0000_2580
`define SCR_RATE_19200 32'h0000_4B00
`define SCR_RATE_38400 32'h0000_9600
`define SCR_RATE_57600 32'h0000_E100
`define SCR_RATE_115200 32'h0001_C200
`define SCR_RATE_128000 32'h0001_F400
`define SCR_RATE_230400 32'h0003_8400
`define SCR_RATE_460800 32'h0007_0800
`define SCR_RATE_921600 32'h000E_1000
`define SCR_FIFO_DEPTH 4
`endif

// >>> src/scr_pkg.sv
// Types shared by the serial configuration register block
`default_nettype none
package scr_pkg;
  typedef enum logic [1:0] {SCR_CMD_READ, SCR_CMD_WRITE, SCR_CMD_ASYNC} scr_kind_t;
  typedef struct packed {
    scr_kind_t kind;
    logic [7:0] reg_id;
    logic [31:0] value;
    logic port_given;
    logic [7:0] port_sel;
    logic src_port;
  } scr_cmd_t;
  typedef struct packed {
    scr_kind_t kind;
    logic [7:0] reg_id;
    logic [31:0] value;
    logic port_given;
    logic [7:0] port_sel;
    logic src_port;
    logic [7:0] err;
  } scr_rsp_t;
  typedef enum logic [1:0] {SCR_IDLE, SCR_REPLY, SCR_WAIT_TX} scr_state_t;
endpackage
`default_nettype wire

// >>> src/scr_fifo.sv
// Small register FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module scr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] count_reg, count_next;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem_reg[rd_ptr_reg];
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_next;
      // Flags registered from the next count so both stay honest
      in_ready <= count_next != (AW+1)'(DEPTH);
      out_valid <= count_next != '0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/scr_regs_chk.sv
// Port-level assertions for the serial configuration register block
`timescale 1ns/1ps
`default_nettype none
module scr_regs_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire scr_pkg::scr_rsp_t rsp,
  input wire logic [1:0] tx_idle,
  input wire logic [1:0][31:0] line_rate,
  input wire logic [1:0] rate_switch,
  input wire logic [1:0][7:0] async_output_type_select,
  input wire logic [1:0] async_paused,
  input wire logic [1:0] async_emit,
  input wire logic custom_build
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire ok_wr = rsp_valid && rsp.err == 8'h00 && rsp.kind == scr_pkg::SCR_CMD_WRITE;
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("reply changed before accept");
  echo_port_a: assert property (rsp_valid && !rsp.port_given |-> rsp.port_sel == 8'h00)
    else $error("port echoed without request");
  rev_ro_a: assert property (rsp_valid && rsp.kind == scr_pkg::SCR_CMD_WRITE && rsp.reg_id == 8'h04
    |-> rsp.err == 8'h06) else $error("revision write accepted");
  rev_custom_a: assert property (rsp_valid && rsp.reg_id == 8'h04 && rsp.kind == scr_pkg::SCR_CMD_READ
    |-> custom_build == (rsp.value[31:24] > 8'h64)) else $error("custom flag wrong");
  rate_set_a: assert property (ok_wr && rsp.reg_id == 8'h05 |-> rsp.value inside {32'h2580, 32'h4B00,
    32'h9600, 32'hE100, 32'h1C200, 32'h1F400, 32'h38400, 32'h70800, 32'hE1000}) else $error("bad rate taken");
  type_set_a: assert property (ok_wr && rsp.reg_id == 8'h06 |-> rsp.value inside {32'h0, 32'h1, 32'h2,
    32'h8, [32'hA:32'hE], 32'h10, 32'h11, [32'h13:32'h17], [32'h1C:32'h1E]}) else $error("bad type taken");
  rate_wait_a: assert property ($changed(line_rate[0]) |-> $past(tx_idle[0]))
    else $error("rate switched while sending");
  rate_pulse_a: assert property ($changed(line_rate[0]) |-> ##[0:1] rate_switch[0])
    else $error("no rate switch pulse");
  off_quiet_a: assert property ((async_output_type_select[1] == 8'h00) [*2] |-> !async_emit[1])
    else $error("emit with output off");
  pause_quiet_a: assert property (async_paused[0] [*2] |-> !async_emit[0])
    else $error("emit while paused");
  emit_gap_a: assert property (async_emit[0] |=> !async_emit[0] [*8])
    else $error("emits too close");
endmodule
bind scr_config_regs scr_regs_chk u_chk (.clk, .sys_rst, .rsp_valid, .rsp_ready, .rsp, .tx_idle, .line_rate,
  .rate_switch, .async_output_type_select, .async_paused, .async_emit, .custom_build);
`default_nettype wire

// >>> bench/scr_host_model.sv
// Host side: takes replies, optionally stalling, and models busy transmitters
`timescale 1ns/1ps
`default_nettype none
module scr_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic rsp_valid,
  input wire scr_pkg::scr_rsp_t rsp,
  output logic rsp_ready,
  output logic [1:0] tx_idle
);
  logic [2:0] busy_cnt;
  logic busy_port;
  always @(posedge clk) begin
    if (sys_rst) begin
      rsp_ready <= 1'b0;
      busy_cnt <= 3'h0;
      busy_port <= 1'b0;
    end else begin
      rsp_ready <= slow ? ~rsp_ready : 1'b1;
      if (rsp_valid && rsp_ready) begin
        busy_cnt <= 3'h6; // Reply still on the wire
        busy_port <= rsp.src_port;
      end else if (busy_cnt != 3'h0) begin
        busy_cnt <= busy_cnt - 3'h1;
      end
    end
  end
  assign tx_idle = (busy_cnt == 3'h0) ? 2'h3 : (busy_port ? 2'h1 : 2'h2);
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the serial configuration register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic slow = 1'b0;
  scr_pkg::scr_cmd_t cmd = '0;
  logic [1:0][31:0] async_output_rate = {32'hC8, 32'hC8}; // Listed 200 Hz on both ports
  logic cmd_ready, rsp_valid, rsp_ready, custom_build;
  scr_pkg::scr_rsp_t rsp, got;
  logic [1:0] tx_idle, rate_switch, async_paused, async_emit;
  logic [1:0][31:0] line_rate;
  logic [1:0][7:0] async_output_type_select;
  int error_cnt = 0;
  int cmp_count = 0;
  // Arbitrary revision values; patch above 100 marks a custom build
  scr_config_regs #(.CLK_HZ(2000), .REV_MAJOR(8'h01), .REV_MINOR(8'h02), .REV_FEATURE(8'h03),
    .REV_PATCH(8'h65)) u_scr_config_regs (.clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd, .rsp_valid,
    .rsp_ready, .rsp, .tx_idle, .async_output_rate, .line_rate, .rate_switch, .async_output_type_select,
    .async_paused, .async_emit, .custom_build);
  scr_host_model u_scr_host_model (.clk, .sys_rst, .slow, .rsp_valid, .rsp, .rsp_ready, .tx_idle);
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input scr_pkg::scr_kind_t k, input logic [7:0] id, input logic [31:0] v,
    input logic [7:0] ps, input logic src);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= '{k, id, v, ps != 8'h00, ps, src};
    do @(posedge clk); while (!cmd_ready && ++n < 300);
    cmd_valid <= 1'b0;
    do @(posedge clk); while (!(rsp_valid && rsp_ready) && ++n < 300);
    got = rsp;
    chk(n < 300, 32'h1);
  endtask
  task automatic cnt(output int a, output int b);
    a = 0;
    b = 0;
    repeat (3) @(posedge clk);
    repeat (100) begin
      @(posedge clk);
      a += async_emit[0];
      b += async_emit[1];
    end
  endtask
  task automatic t_rev;
    xfer(scr_pkg::SCR_CMD_READ, 8'h04, 32'h0, 8'h00, 1'b0);
    chk(got.value, 32'h6503_0201);
    chk(custom_build, 32'h1);
    xfer(scr_pkg::SCR_CMD_WRITE, 8'h04, 32'h0, 8'h00, 1'b0);
    chk(got.err, 32'h6);
    xfer(scr_pkg::SCR_CMD_READ, 8'h09, 32'h0, 8'h00, 1'b0);
    chk(got.err, 32'h5);
    $display("revision test done");
  endtask
  task automatic t_rate;
    logic [31:0] r[9] = '{32'h2580, 32'h4B00, 32'h9600, 32'hE100, 32'h1C200, 32'h1F400, 32'h38400,
      32'h70800, 32'hE1000};
    int n;
    slow <= 1'b1;
    foreach (r[i]) begin
      xfer(scr_pkg::SCR_CMD_WRITE, 8'h05, r[i], 8'h02, 1'b0);
      chk(got.port_sel, 32'h2);
      repeat (12) @(posedge clk);
      chk(line_rate[1], r[i]);
    end
    slow <= 1'b0;
    xfer(scr_pkg::SCR_CMD_WRITE, 8'h05, 32'h2581, 8'h00, 1'b1);
    chk(got.err, 32'h4);
    xfer(scr_pkg::SCR_CMD_WRITE, 8'h05, r[0], 8'h03, 1'b1);
    chk(got.err, 32'h4);
    xfer(scr_pkg::SCR_CMD_READ, 8'h05, 32'h0, 8'h00, 1'b1);
    chk(got.value, r[8]);
    xfer(scr_pkg::SCR_CMD_WRITE, 8'h05, r[0], 8'h00, 1'b0);
    chk(got.port_given, 32'h0);
    @(posedge clk);
    chk(line_rate[0], 32'h1C200);
    n = 0;
    repeat (12) begin
      @(posedge clk);
      n += rate_switch[0];
    end
    chk(n, 32'h1);
    chk(line_rate[0], r[0]);
    $display("line rate test done");
  endtask
  task automatic t_type;
    logic [7:0] c[18] = '{8'h01, 8'h02, 8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h13,
      8'h14, 8'h15, 8'h16, 8'h17, 8'h1C, 8'h1D, 8'h1E};
    int a, b;
    foreach (c[i]) begin
      xfer(scr_pkg::SCR_CMD_WRITE, 8'h06, {24'h0, c[i]}, 8'h02, 1'b0);
      @(posedge clk);
      chk(async_output_type_select[1], c[i]);
    end
    xfer(scr_pkg::SCR_CMD_WRITE, 8'h06, 32'h0, 8'h02, 1'b0);
    xfer(scr_pkg::SCR_CMD_WRITE, 8'h06, 32'h1, 8'h00, 1'b0);
    @(posedge clk);
    chk(async_output_type_select[0], 32'h1);
    xfer(scr_pkg::SCR_CMD_WRITE, 8'h06, 32'h3, 8'h00, 1'b0);
    chk(got.err, 32'h4);
    xfer(scr_pkg::SCR_CMD_READ, 8'h06, 32'h0, 8'h00, 1'b0);
    chk(got.value, 32'h1);
    chk(async_output_type_select[0], 32'h1);
    cnt(a, b);
    chk(a, 32'hA);
    chk(b, 32'h0);
    $display("output type test done");
  endtask
  task automatic t_pause;
    int a, b;
    xfer(scr_pkg::SCR_CMD_ASYNC, 8'h00, 32'h0, 8'h00, 1'b0);
    cnt(a, b);
    chk(a, 32'h0);
    chk(async_paused[0], 32'h1);
    chk(async_output_type_select[0], 32'h1);
    xfer(scr_pkg::SCR_CMD_ASYNC, 8'h00, 32'h1, 8'h00, 1'b0);
    cnt(a, b);
    chk(a, 32'hA);
    chk(async_paused[0], 32'h0);
    async_output_rate[0] <= 32'h64;
    cnt(a, b);
    chk(a, 32'h5);
    async_output_rate[0] <= 32'h3;
    cnt(a, b);
    chk(a, 32'h0);
    $display("pause test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_rev;
    t_rate;
    t_type;
    t_pause;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
